/* common/sbc_id_pkg.sv */
// constants for the identification word and serial register access
package sbc_id_pkg;
   localparam int          FRAME_BITS     = 16;
   localparam int          SEL_BITS       = 3;
   localparam int          DATA_BITS      = 12;
   localparam int          CNT_BITS       = 5;
   localparam int          SEL_MSB        = 15;
   localparam int          SEL_LSB        = 13;
   localparam int          WRITE_BIT      = 12;
   localparam int          ID_FLAG_BIT    = 11;
   localparam int          VERSION_MSB    = 10;
   localparam int          VERSION_LSB    = 7;
   localparam int          TYPE_MSB       = 6;
   localparam int          TYPE_LSB       = 0;
   localparam logic [2:0]  SEL_GP0        = 3'h0;
   localparam logic [2:0]  SEL_GP1        = 3'h1;
   localparam logic [2:0]  SEL_WAKE_EN    = 3'h2;
   localparam logic [2:0]  SEL_STATUS     = 3'h7;
   localparam logic [4:0]  CNT_SEL_LAST   = 5'h02;
   localparam logic [4:0]  CNT_DATA_FIRST = 5'h04;
   localparam logic [4:0]  CNT_DATA_LAST  = 5'h0f;
   localparam logic [4:0]  CNT_FULL       = 5'h10;
   localparam logic [4:0]  CNT_SAT        = 5'h1f;
   localparam logic [11:0] GP1_RESET      = 12'h000;
   localparam logic [11:0] WAKE_EN_RESET  = 12'h003;
   // sync reset levels: sck low, chip select high, data low, back supply low
   localparam logic [3:0]  PIN_RESET      = 4'h4;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_SHIFT = 2'b01,
      ST_LOCK  = 2'b10
   } spi_state_type;
endpackage : sbc_id_pkg

/* src/pin_sync.sv */
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
   parameter int               WIDTH     = 4,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             clk_sys_in,
   input  wire logic             arst_n_in,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   if (WIDTH < 1) begin : g_chk
      $error("pin_sync needs at least one bit");
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         meta_q   <= RESET_VAL;
         sync_out <= RESET_VAL;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : pin_sync

/* src/sbc_id_regs.sv */
// serial register slave with identification word, mode lockout and wake suppression
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////////////////////////
module sbc_id_regs #(
   parameter logic [6:0] DEVICE_TYPE = 7'h2a,   // arbitrary value
   parameter logic [3:0] SILICON_VER = 4'h3     // arbitrary value
) (
   input  wire logic       clk_sys_in,
   input  wire logic       arst_n_in,
   input  wire logic       sck_in,
   input  wire logic       cs_n_in,
   input  wire logic       sdi_in,
   input  wire logic       back_supply_in,
   input  wire logic       forced_normal_in,
   input  wire logic       flash_mode_in,
   input  wire logic       failsafe_mode_in,
   input  wire logic [1:0] suppress_req_in,
   input  wire logic [1:0] wake_event_in,
   output logic            sdo_out,
   output logic            sdo_oe_out,
   output logic            rst_n_out,
   output logic [1:0]      wake_out
);
   import sbc_id_pkg::*;

   localparam logic [11:0] ID_WORD = {1'b0, SILICON_VER, DEVICE_TYPE};

   logic [3:0]     pins_s;
   logic           sck_s;
   logic           cs_n_s;
   logic           sdi_s;
   logic           back_s;
   logic           sck_q;
   spi_state_type  state_q;
   spi_state_type  state_d;
   logic [4:0]     cnt_q;
   logic [15:0]    rx_q;
   logic [2:0]     sel_q;
   logic [11:0]    rd_q;
   logic           sdo_q;
   logic           oe_q;
   logic           rst_n_q;
   logic [11:0]    gp0_q;
   logic [11:0]    gp1_q;
   logic [11:0]    wake_en_q;
   logic [1:0]     supp_q;
   logic [1:0]     wake_q;

   pin_sync #(
      .WIDTH     (4),
      .RESET_VAL (PIN_RESET)
   ) u_sync (
      .clk_sys_in (clk_sys_in),
      .arst_n_in  (arst_n_in),
      .async_in   ({sck_in, cs_n_in, sdi_in, back_supply_in}),
      .sync_out   (pins_s)
   );

   assign sck_s  = pins_s[3];
   assign cs_n_s = pins_s[2];
   assign sdi_s  = pins_s[1];
   assign back_s = pins_s[0];

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // decode

   function automatic logic [11:0] read_mux(input logic [2:0] sel, input logic [11:0] g0,
                                            input logic [11:0] g1, input logic [11:0] en,
                                            input logic [11:0] st);
      logic [11:0] r;
      r = 12'h000;
      case (sel)
         SEL_GP0:     r = g0;
         SEL_GP1:     r = g1;
         SEL_WAKE_EN: r = en;
         SEL_STATUS:  r = st;
         default:     r = 12'h000;
      endcase
      return r;
   endfunction : read_mux

   wire        sck_rise    = sck_s & ~sck_q;
   wire        sck_fall    = ~sck_s & sck_q;
   wire        in_shift    = (state_q == ST_SHIFT);
   wire        frame_start = (state_q == ST_IDLE) & ~cs_n_s & ~forced_normal_in;
   wire        frame_end   = in_shift & cs_n_s & ~forced_normal_in;
   wire [2:0]  sel_now     = {rx_q[1:0], sdi_s};
   wire        sel_done    = in_shift & ~cs_n_s & sck_fall & (cnt_q == CNT_SEL_LAST);
   wire [2:0]  wr_sel      = rx_q[SEL_MSB:SEL_LSB];
   wire [11:0] wr_data     = rx_q[DATA_BITS-1:0];
   // writes only on a clean frame of exactly sixteen bits; lockout aborts a frame
   wire        wr_fire     = frame_end & (cnt_q == CNT_FULL) & rx_q[WRITE_BIT];
   wire [11:0] status_w    = {6'h00, failsafe_mode_in, flash_mode_in, forced_normal_in,
                              back_s, supp_q};
   wire [11:0] rd_now      = read_mux(sel_now, gp0_q, gp1_q, wake_en_q, status_w);
   wire [3:0]  out_idx     = 4'(CNT_DATA_LAST - cnt_q);
   wire        data_phase  = (cnt_q >= CNT_DATA_FIRST) && (cnt_q <= CNT_DATA_LAST);

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:  if (forced_normal_in) state_d = ST_LOCK;
                   else if (!cs_n_s) state_d = ST_SHIFT;
         ST_SHIFT: if (forced_normal_in) state_d = ST_LOCK;
                   else if (cs_n_s) state_d = ST_IDLE;
         ST_LOCK:  if (!forced_normal_in && cs_n_s) state_d = ST_IDLE;
         default:  state_d = ST_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // serial shifter

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_q <= ST_IDLE;
         sck_q   <= 1'b0;
         cnt_q   <= 5'h00;
         rx_q    <= 16'h0000;
         sel_q   <= 3'h0;
         rd_q    <= 12'h000;
         sdo_q   <= 1'b0;
         oe_q    <= 1'b0;
      end else begin
         state_q <= state_d;
         sck_q   <= sck_s;
         oe_q    <= (state_d == ST_SHIFT);
         if (frame_start) begin
            cnt_q <= 5'h00;
            sdo_q <= 1'b0;
         end else if (in_shift && !cs_n_s) begin
            if (sck_fall) begin
               rx_q <= {rx_q[14:0], sdi_s};
               if (cnt_q != CNT_SAT) cnt_q <= cnt_q + 5'h01;
            end
            if (sel_done) begin
               sel_q <= sel_now;
               rd_q  <= rd_now;
            end
            if (sck_rise) sdo_q <= data_phase ? rd_q[out_idx] : 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         gp0_q     <= ID_WORD;
         gp1_q     <= GP1_RESET;
         wake_en_q <= WAKE_EN_RESET;
      end else if (wr_fire) begin
         if (wr_sel == SEL_GP0) begin
            gp0_q[VERSION_MSB:TYPE_LSB] <= wr_data[VERSION_MSB:TYPE_LSB];
            gp0_q[ID_FLAG_BIT]          <= 1'b1;
         end
         if (wr_sel == SEL_GP1) gp1_q <= wr_data;
         if (wr_sel == SEL_WAKE_EN) wake_en_q <= wr_data;
      end
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         supp_q  <= 2'h0;
         wake_q  <= 2'h0;
         rst_n_q <= 1'b0;
      end else begin
         supp_q  <= failsafe_mode_in ? (supp_q | suppress_req_in) : 2'h0;
         wake_q  <= wake_event_in & ~supp_q & wake_en_q[1:0];
         rst_n_q <= ~back_s;
      end
   end

   assign sdo_out    = sdo_q;
   assign sdo_oe_out = oe_q;
   assign rst_n_out  = rst_n_q;
   assign wake_out   = wake_q;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!arst_n_in);

   sequence s_sel_seen;
      sel_done;
   endsequence
   sequence s_sel_loaded;
      ##1 (sel_q == $past(sel_now)) && (rd_q == $past(rd_now));
   endsequence

   property p_lock_release;
      forced_normal_in |=> !sdo_oe_out;
   endproperty
   a_lock_release: assert property (p_lock_release) else $error("sdo driven in lockout");

   property p_lock_nowrite;
      forced_normal_in |=> ($stable(gp0_q) && $stable(gp1_q) && $stable(wake_en_q));
   endproperty
   a_lock_nowrite: assert property (p_lock_nowrite) else $error("write during lockout");

   property p_gp1_store;
      (wr_fire && wr_sel == SEL_GP1) |=> (gp1_q == $past(wr_data));
   endproperty
   a_gp1_store: assert property (p_gp1_store) else $error("general word one not stored");

   property p_back_reset;
      back_s |=> !rst_n_out;
   endproperty
   a_back_reset: assert property (p_back_reset) else $error("reset not low on back supply");

   property p_sel_capture;
      s_sel_seen |-> s_sel_loaded;
   endproperty
   a_sel_capture: assert property (p_sel_capture) else $error("selector not captured");

   property p_sdo_stable;
      (!sck_rise && !frame_start) |=> $stable(sdo_out);
   endproperty
   a_sdo_stable: assert property (p_sdo_stable) else $error("sdo moved off rising edge");

   property p_supp_end;
      !failsafe_mode_in |=> (supp_q == 2'h0) ##1 (wake_out == $past(wake_event_in & wake_en_q[1:0]));
   endproperty
   a_supp_end: assert property (p_supp_end) else $error("suppression kept after fail-safe");

   property p_id_intact;
      !gp0_q[ID_FLAG_BIT] |-> (gp0_q == ID_WORD);
   endproperty
   a_id_intact: assert property (p_id_intact) else $error("id word changed with flag clear");

   property p_flag_sticky;
      gp0_q[ID_FLAG_BIT] |=> gp0_q[ID_FLAG_BIT] [*3];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("overwritten flag cleared");

   property p_flag_ignores;
      (wr_fire && wr_sel == SEL_GP0 && !wr_data[ID_FLAG_BIT]) |=> gp0_q[ID_FLAG_BIT];
   endproperty
   a_flag_ignores: assert property (p_flag_ignores) else $error("flag took written value");
endmodule : sbc_id_regs

/* verif/spi_host_model.sv */
// serial host model that drives frames into the register block
`timescale 1ns/1ps
module spi_host_model (
   input  wire logic clk_sys_in,
   input  wire logic sdo_in,
   input  wire logic sdo_oe_in,
   output logic      sck_out,
   output logic      cs_n_out,
   output logic      sdi_out
);
   // eight system clocks per phase keeps the synchronisers well inside margin
   localparam int HALF = 8;
   logic oe_seen;
   initial begin
      sck_out  = 1'b0;
      cs_n_out = 1'b1;
      sdi_out  = 1'b0;
      oe_seen  = 1'b0;
   end
   always @(posedge clk_sys_in) begin
      if (sdo_oe_in === 1'b1) begin
         oe_seen <= 1'b1;
      end
   end
   task automatic xfer(input logic [15:0] frame, input int nbits, output logic [11:0] rd);
      rd      = 12'h000;
      oe_seen = 1'b0;
      @(negedge clk_sys_in);
      cs_n_out = 1'b0;
      repeat (HALF) @(negedge clk_sys_in);
      for (int k = 1; k <= nbits; k++) begin
         sck_out = 1'b1;
         sdi_out = frame[16-k];
         repeat (HALF) @(negedge clk_sys_in);
         sck_out = 1'b0;
         // selector and write-bit slots carry no data; data bit 11 sits in slot five
         if (k >= 5 && k <= 16) begin
            rd[16-k] = sdo_in;
         end
         repeat (HALF) @(negedge clk_sys_in);
      end
      cs_n_out = 1'b1;
      // released data line: show the inverse of the last bit, never a stale copy
      sdi_out = ~sdi_out;
      repeat (2*HALF) @(negedge clk_sys_in);
   endtask : xfer
endmodule : spi_host_model

/* verif/sbc_id_and_spi_mode_behaviour_bench.sv */
// self-checking bench for the identification word and serial mode behaviour
`timescale 1ns/1ps
module sbc_id_and_spi_mode_behaviour_bench;
   import sbc_id_pkg::*;
   localparam logic [11:0] ID_VAL = {1'b0, 4'h3, 7'h2a};
   logic        clk_sys_in, arst_n_in, sck, cs_n, sdi, sdo, sdo_oe, rst_n;
   logic        back_supply, forced_normal, flash_mode, failsafe;
   logic [1:0]  suppress_req, wake_event, wake;
   logic [11:0] rd;
   int          n_fail, comparisons;

   sbc_id_regs #(.DEVICE_TYPE(7'h2a), .SILICON_VER(4'h3)) sbc_id_regs_inst (
      .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .sck_in(sck), .cs_n_in(cs_n),
      .sdi_in(sdi), .back_supply_in(back_supply), .forced_normal_in(forced_normal),
      .flash_mode_in(flash_mode), .failsafe_mode_in(failsafe),
      .suppress_req_in(suppress_req), .wake_event_in(wake_event), .sdo_out(sdo),
      .sdo_oe_out(sdo_oe), .rst_n_out(rst_n), .wake_out(wake));
   spi_host_model spi_host_model_inst (
      .clk_sys_in(clk_sys_in), .sdo_in(sdo), .sdo_oe_in(sdo_oe),
      .sck_out(sck), .cs_n_out(cs_n), .sdi_out(sdi));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [2:0] sel, input logic [11:0] d, input int nb);
      spi_host_model_inst.xfer({sel, 1'b1, d}, nb, rd);
   endtask : wr
   task automatic rdr(input logic [2:0] sel);
      spi_host_model_inst.xfer({sel, 1'b0, 12'h000}, 16, rd);
   endtask : rdr
   task automatic close_out;
      if (n_fail == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : close_out

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_id;
      rdr(SEL_GP0);
      check(16'(rd[ID_FLAG_BIT]), 16'h0000);
      check(16'(rd[VERSION_MSB:VERSION_LSB]), 16'h0003);
      check(16'(rd[TYPE_MSB:TYPE_LSB]), 16'h002a);
      check(16'(rd), 16'(ID_VAL));
      check(16'(spi_host_model_inst.oe_seen), 16'h0001);
      check(16'(rst_n), 16'h0001);
   endtask : t_id
   task automatic t_gp0_write;
      // flag bit written as zero must still come back set
      wr(SEL_GP0, 12'h155, 16);
      rdr(SEL_GP0);
      check(16'(rd), 16'h0955);
      wr(SEL_GP0, 12'h000, 16);
      rdr(SEL_GP0);
      check(16'(rd), 16'h0800);
   endtask : t_gp0_write
   task automatic t_flash;
      flash_mode = 1'b1;
      wr(SEL_GP1, 12'habc, 16);
      // a short frame must leave the word alone
      wr(SEL_GP1, 12'h123, 15);
      rdr(SEL_GP1);
      check(16'(rd), 16'h0abc);
      rdr(SEL_GP0);
      check(16'(rd), 16'h0800);
      flash_mode = 1'b0;
   endtask : t_flash
   task automatic t_forced;
      forced_normal = 1'b1;
      wr(SEL_GP1, 12'h555, 16);
      check(16'(spi_host_model_inst.oe_seen), 16'h0000);
      forced_normal = 1'b0;
      rdr(SEL_GP1);
      check(16'(rd), 16'h0abc);
   endtask : t_forced
   task automatic t_back;
      back_supply = 1'b1;
      repeat (4) @(negedge clk_sys_in);
      check(16'(rst_n), 16'h0000);
      back_supply = 1'b0;
      repeat (4) @(negedge clk_sys_in);
      check(16'(rst_n), 16'h0001);
   endtask : t_back
   task automatic t_wake;
      failsafe     = 1'b1;
      suppress_req = 2'b01;
      @(negedge clk_sys_in);
      suppress_req = 2'b00;
      wake_event   = 2'b11;
      repeat (3) @(negedge clk_sys_in);
      check(16'(wake), 16'h0002);
      // status shows fail-safe set and channel zero suppressed
      rdr(SEL_STATUS);
      check(16'(rd), 16'h0021);
      failsafe = 1'b0;
      repeat (3) @(negedge clk_sys_in);
      check(16'(wake), 16'h0003);
      wake_event = 2'b00;
      // enable mask gates channel one off
      wr(SEL_WAKE_EN, 12'h001, 16);
      wake_event = 2'b11;
      repeat (3) @(negedge clk_sys_in);
      check(16'(wake), 16'h0001);
      wake_event = 2'b00;
      rdr(SEL_WAKE_EN);
      check(16'(rd), 16'h0001);
   endtask : t_wake
   task automatic t_por;
      // a second power-on clears the overwritten flag and reloads the id
      @(negedge clk_sys_in);
      arst_n_in = 1'b0;
      repeat (2) @(negedge clk_sys_in);
      arst_n_in = 1'b1;
      repeat (4) @(negedge clk_sys_in);
      rdr(SEL_GP0);
      check(16'(rd), 16'(ID_VAL));
      rdr(SEL_GP1);
      check(16'(rd), 16'(GP1_RESET));
   endtask : t_por

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   initial begin
      #200000;
      n_fail++;
      close_out;
   end
   initial begin
      n_fail        = 0;
      comparisons   = 0;
      arst_n_in     = 1'b0;
      back_supply   = 1'b0;
      forced_normal = 1'b0;
      flash_mode    = 1'b0;
      failsafe      = 1'b0;
      suppress_req  = 2'b00;
      wake_event    = 2'b00;
      repeat (6) @(negedge clk_sys_in);
      arst_n_in = 1'b1;
      repeat (4) @(negedge clk_sys_in);
      t_id;
      t_gp0_write;
      t_flash;
      t_forced;
      t_back;
      t_wake;
      t_por;
      close_out;
   end
endmodule : sbc_id_and_spi_mode_behaviour_bench
